// File: verilog/epd_command_decoder.sv
// Purpose: Command decoder and update sequencer
// Assumes: Serial link clock is asynchronous to core_clk
// Notes: Config appears on plain output ports
`timescale 1ns/1ps
module epd_command_decoder #(
	parameter int LUT_N = epd_cmd_pkg::LUT_BYTES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_data_in,
	input wire logic dc_pin,
	input wire logic wire_count_select,
	input wire logic panel_break_pin,
	input wire logic [4:0] lut_rd_index,
	output logic busy,
	output logic ram_we,
	output logic [4:0] ram_x,
	output logic [7:0] ram_y,
	output logic [7:0] ram_wdata,
	output logic [2:0] stage_index,
	output logic stage_valid,
	output logic internal_clock_enable,
	output logic deep_sleep,
	output logic [15:0] temp_value,
	output logic [7:0] vcom_code,
	output logic [7:0] status_byte,
	output logic [7:0] lut_byte,
	output logic [6:0] dummy_period,
	output logic [3:0] gate_width,
	output logic bypass_enable,
	output logic bypass_value,
	output logic [1:0] source_mapping,
	output logic border_follow,
	output logic border_fixed,
	output logic [1:0] border_level,
	output logic [1:0] border_transition
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (LUT_N < 1 || LUT_N > 31) begin : g_chk
		$error("LUT_N out of range");
	end
	// ----------------------------------------
	// Link crossing
	// ----------------------------------------
	logic [7:0] link_byte; // Stable while toggle settles
	logic link_dc; // Command/data of that byte
	logic link_tog; // Flips per byte
	logic tog_sync; // Toggle in core domain
	logic tog_d_reg; // Previous synced toggle
	logic brk_sync; // Synced break pin
	serial_rx u_rx (
		.sclk(sclk),
		.rst(rst),
		.cs_n(cs_n),
		.serial_data_in(serial_data_in),
		.dc_pin(dc_pin),
		.wire_count_select(wire_count_select),
		.byte_reg(link_byte),
		.dc_reg(link_dc),
		.toggle_reg(link_tog)
	);
	bit_sync #(.WIDTH(2)) u_sync (
		.clk(core_clk),
		.rst(rst),
		.din({link_tog, panel_break_pin}),
		.dout({tog_sync, brk_sync})
	);
	// Edge of the synced toggle
	always_ff @(posedge core_clk) begin
		tog_d_reg <= rst ? 1'b0 : tog_sync;
	end
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	epd_cmd_pkg::seq_state_t state_reg; // Sequencer state
	logic [7:0] cmd_reg; // Last command byte
	logic [4:0] pidx_reg; // Parameter position
	wire evt = tog_sync ^ tog_d_reg;
	wire idle = state_reg == epd_cmd_pkg::SEQ_IDLE;
	wire cmd_hit = evt && !link_dc && idle;
	wire dat_hit = evt && link_dc && idle;
	wire swrst_hit = cmd_hit && link_byte == epd_cmd_pkg::CMD_SWRST;
	wire act_hit = cmd_hit && link_byte == epd_cmd_pkg::CMD_ACT;
	wire det_hit = cmd_hit && link_byte == epd_cmd_pkg::CMD_DETECT && internal_clock_enable;
	wire cfg_dflt = rst || swrst_hit;
	wire p0 = dat_hit && pidx_reg == 5'h00;
	wire p1 = dat_hit && pidx_reg == 5'h01;
	wire is_cmd_entry = cmd_reg == epd_cmd_pkg::CMD_ENTRY;
	wire ram_hit = dat_hit && cmd_reg == epd_cmd_pkg::CMD_WRAM;
	// Command byte and parameter position
	always_ff @(posedge core_clk) begin
		if (cfg_dflt) begin
			cmd_reg <= 8'h00;
			pidx_reg <= 5'h00;
		end else if (cmd_hit) begin
			cmd_reg <= link_byte;
			pidx_reg <= 5'h00;
		end else if (dat_hit && pidx_reg != 5'h1f) begin
			pidx_reg <= pidx_reg + 5'h01;
		end
	end
	// ----------------------------------------
	// Settings
	// ----------------------------------------
	logic [2:0] entry_reg; // Step and axis
	logic [7:0] upd1_reg; // Update control 1
	logic [7:0] upd2_reg; // Update control 2
	logic [7:0] border_reg; // Border control
	logic [4:0] xs_reg; // X window start
	logic [4:0] xe_reg; // X window end
	logic [7:0] ys_reg; // Y window start
	logic [7:0] ye_reg; // Y window end
	logic [7:0] lut_reg [LUT_N]; // Table storage
	// Parameter capture per command
	always_ff @(posedge core_clk) begin
		if (cfg_dflt) begin
			entry_reg <= epd_cmd_pkg::ENTRY_RST;
			temp_value <= epd_cmd_pkg::TEMP_RST;
			upd1_reg <= epd_cmd_pkg::UPD1_RST;
			upd2_reg <= epd_cmd_pkg::UPD2_RST;
			vcom_code <= epd_cmd_pkg::VCOM_RST;
			dummy_period <= epd_cmd_pkg::DUMMY_RST;
			gate_width <= epd_cmd_pkg::GATE_RST;
			border_reg <= epd_cmd_pkg::BORDER_RST;
			xs_reg <= 5'h00;
			xe_reg <= epd_cmd_pkg::XEND_RST;
			ys_reg <= 8'h00;
			ye_reg <= epd_cmd_pkg::YEND_RST;
		end else if (dat_hit) begin
			unique case (cmd_reg)
				epd_cmd_pkg::CMD_ENTRY: if (pidx_reg == 5'h00) entry_reg <= link_byte[2:0];
				epd_cmd_pkg::CMD_TEMP: begin
					if (p0) temp_value[15:8] <= link_byte;
					if (p1) temp_value[7:0] <= link_byte;
				end
				epd_cmd_pkg::CMD_UPD1: if (p0) upd1_reg <= link_byte;
				epd_cmd_pkg::CMD_UPD2: if (p0) upd2_reg <= link_byte;
				epd_cmd_pkg::CMD_VCOM: if (p0) vcom_code <= link_byte;
				epd_cmd_pkg::CMD_DUMMY: if (p0) dummy_period <= link_byte[6:0];
				epd_cmd_pkg::CMD_GATE: if (p0) gate_width <= link_byte[3:0];
				epd_cmd_pkg::CMD_BORDER: if (p0) border_reg <= link_byte;
				epd_cmd_pkg::CMD_XWIN: begin
					if (p0) xs_reg <= link_byte[4:0];
					if (p1) xe_reg <= link_byte[4:0];
				end
				epd_cmd_pkg::CMD_YWIN: begin
					if (p0) ys_reg <= link_byte;
					if (p1) ye_reg <= link_byte;
				end
				default: ;
			endcase
		end
	end
	// Table bytes stored by position
	always_ff @(posedge core_clk) begin
		if (dat_hit && cmd_reg == epd_cmd_pkg::CMD_LUT && pidx_reg < 5'(LUT_N)) begin
			lut_reg[pidx_reg] <= link_byte;
		end
	end
	assign lut_byte = lut_rd_index < 5'(LUT_N) ? lut_reg[lut_rd_index] : 8'h00;
	// Sleep survives software reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			deep_sleep <= 1'b0;
		end else if (p0 && cmd_reg == epd_cmd_pkg::CMD_SLEEP) begin
			deep_sleep <= link_byte[0];
		end
	end
	// Setting fields as outputs
	assign bypass_enable = upd1_reg[epd_cmd_pkg::BYPASS_EN_BIT];
	assign bypass_value = upd1_reg[epd_cmd_pkg::BYPASS_VAL_BIT];
	assign source_mapping = upd1_reg[1:0];
	assign border_follow = border_reg[epd_cmd_pkg::BORDER_FOLLOW_BIT];
	assign border_fixed = border_reg[epd_cmd_pkg::BORDER_FIXED_BIT];
	assign border_level = border_reg[5:4];
	assign border_transition = border_reg[1:0];
	// ----------------------------------------
	// Address counter
	// ----------------------------------------
	wire x_inc = entry_reg[0];
	wire y_inc = entry_reg[1];
	wire adv_y = entry_reg[epd_cmd_pkg::ENTRY_AXIS_BIT];
	wire x_edge = x_inc ? ram_x == xe_reg : ram_x == xs_reg;
	wire y_edge = y_inc ? ram_y == ye_reg : ram_y == ys_reg;
	wire [4:0] x_step = x_edge ? (x_inc ? xs_reg : xe_reg) : (x_inc ? ram_x + 5'h01 : ram_x - 5'h01);
	wire [7:0] y_step = y_edge ? (y_inc ? ys_reg : ye_reg) : (y_inc ? ram_y + 8'h01 : ram_y - 8'h01);
	wire [4:0] x_next = (!adv_y || y_edge) ? x_step : ram_x;
	wire [7:0] y_next = (adv_y || x_edge) ? y_step : ram_y;
	// Counter loads and advance after writes
	always_ff @(posedge core_clk) begin
		if (cfg_dflt) begin
			ram_x <= 5'h00;
			ram_y <= 8'h00;
		end else if (p0 && cmd_reg == epd_cmd_pkg::CMD_XCNT) begin
			ram_x <= link_byte[4:0];
		end else if (p0 && cmd_reg == epd_cmd_pkg::CMD_YCNT) begin
			ram_y <= link_byte;
		end else if (ram_we) begin
			ram_x <= x_next;
			ram_y <= y_next;
		end
	end
	// RAM write strobe, one cycle per byte
	always_ff @(posedge core_clk) begin
		ram_we <= !cfg_dflt && ram_hit;
		if (cfg_dflt) begin
			ram_wdata <= 8'h00;
		end else if (ram_hit) begin
			ram_wdata <= link_byte;
		end
	end
	// ----------------------------------------
	// Update and detection sequencer
	// ----------------------------------------
	logic [12:0] timer_reg; // Cycles left in step
	logic brk_flag_reg; // Break result
	logic [7:0] stage_map; // Stage index to enable bit
	always_comb begin
		stage_map = {1'b0, upd2_reg[0], upd2_reg[1], upd2_reg[2], upd2_reg[3], upd2_reg[4],
			upd2_reg[6], upd2_reg[7]};
	end
	wire stage_on = stage_map[stage_index];
	wire step_done = !stage_on || timer_reg == 13'h0001;
	wire last_stage = stage_index == 3'h6;
	assign stage_valid = state_reg == epd_cmd_pkg::SEQ_STAGE && stage_on;
	assign busy = !idle;
	// State, stage index and timer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= epd_cmd_pkg::SEQ_IDLE;
			stage_index <= 3'h0;
			timer_reg <= 13'h0000;
		end else begin
			unique case (state_reg)
				epd_cmd_pkg::SEQ_IDLE: begin
					stage_index <= 3'h0;
					timer_reg <= 13'(epd_cmd_pkg::STAGE_CYC);
					if (act_hit) begin
						state_reg <= epd_cmd_pkg::SEQ_STAGE;
					end else if (det_hit) begin
						state_reg <= epd_cmd_pkg::SEQ_DETECT;
						timer_reg <= 13'(epd_cmd_pkg::DETECT_CYC);
					end
				end
				epd_cmd_pkg::SEQ_STAGE: begin
					if (step_done) begin
						timer_reg <= 13'(epd_cmd_pkg::STAGE_CYC);
						stage_index <= stage_index + 3'h1;
						if (last_stage) state_reg <= epd_cmd_pkg::SEQ_IDLE;
					end else begin
						timer_reg <= timer_reg - 13'h0001;
					end
				end
				epd_cmd_pkg::SEQ_DETECT: begin
					timer_reg <= timer_reg - 13'h0001;
					if (timer_reg == 13'h0001) state_reg <= epd_cmd_pkg::SEQ_IDLE;
				end
				default: state_reg <= epd_cmd_pkg::SEQ_IDLE;
			endcase
		end
	end
	// Clock enable from first and last stages
	always_ff @(posedge core_clk) begin
		if (cfg_dflt) begin
			internal_clock_enable <= 1'b0;
		end else if (stage_valid && stage_index == 3'h0) begin
			internal_clock_enable <= 1'b1;
		end else if (stage_valid && last_stage) begin
			internal_clock_enable <= 1'b0;
		end
	end
	// Break result latched at end of detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			brk_flag_reg <= 1'b0;
		end else if (state_reg == epd_cmd_pkg::SEQ_DETECT && timer_reg == 13'h0001) begin
			brk_flag_reg <= brk_sync;
		end
	end
	localparam logic [1:0] CHIP_ID = 2'h2; // Arbitrary identity value
	// Status byte refreshed on read command
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_byte <= 8'h00;
		end else if (cmd_hit && link_byte == epd_cmd_pkg::CMD_STATUS) begin
			status_byte <= {4'h0, brk_flag_reg, 1'b0, CHIP_ID};
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	cmd_route_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_hit && !swrst_hit |=> cmd_reg == $past(link_byte) && pidx_reg == 5'h00) else $error("command not taken");
	ram_stream_a: assert property (@(posedge core_clk) disable iff (rst)
		ram_hit |=> ram_we && ram_wdata == $past(link_byte)) else $error("RAM byte not written");
	x_advance_a: assert property (@(posedge core_clk) disable iff (rst)
		ram_we && !adv_y && x_inc && !x_edge && !dat_hit |=> ram_x == $past(ram_x) + 5'h01)
		else $error("X not advanced");
	software_reset_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
		swrst_hit && !rst |=> temp_value == 16'h7ff0 && ye_reg == 8'hf9 && deep_sleep == $past(deep_sleep))
		else $error("software reset values wrong");
	detect_busy_a: assert property (@(posedge core_clk) disable iff (rst)
		det_hit |=> busy [*8]) else $error("busy dropped in detection");
	stage_order_a: assert property (@(posedge core_clk) disable iff (rst)
		busy && state_reg == epd_cmd_pkg::SEQ_STAGE |=> !busy || stage_index >= $past(stage_index))
		else $error("stage order broken");
	act_busy_a: assert property (@(posedge core_clk) disable iff (rst)
		act_hit |=> busy && stage_index == 3'h0) else $error("activation did not start");
	lut_store_a: assert property (@(posedge core_clk) disable iff (rst)
		dat_hit && cmd_reg == epd_cmd_pkg::CMD_LUT && pidx_reg == 5'h00 |=> lut_reg[0] == $past(link_byte))
		else $error("table byte lost");
	status_fmt_a: assert property (@(posedge core_clk) disable iff (rst)
		status_byte[7:4] == 4'h0 && status_byte[2] == 1'b0) else $error("status reserved bits set");
	busy_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		evt && busy |=> $stable(cmd_reg)) else $error("command taken while busy");
	entry_load_a: assert property (@(posedge core_clk) disable iff (rst)
		p0 && is_cmd_entry |=> entry_reg == $past(link_byte[2:0])) else $error("entry mode not taken");
	xcnt_load_a: assert property (@(posedge core_clk) disable iff (rst)
		p0 && cmd_reg == epd_cmd_pkg::CMD_XCNT |=> ram_x == $past(link_byte[4:0]))
		else $error("X counter not loaded");
	temp_lsb_a: assert property (@(posedge core_clk) disable iff (rst)
		p1 && cmd_reg == epd_cmd_pkg::CMD_TEMP |=> temp_value[7:0] == $past(link_byte))
		else $error("temperature low byte lost");
	// ----------------------------------------
	// Detection length helper
	// ----------------------------------------
	// Counts cycles spent in detection; a long run would hold busy too long
	logic [12:0] det_cnt_reg; // Cycles in detection so far
	always_ff @(posedge core_clk) begin
		if (rst || state_reg != epd_cmd_pkg::SEQ_DETECT) begin
			det_cnt_reg <= 13'h0000; // Idle or updating
		end else begin
			det_cnt_reg <= det_cnt_reg + 13'h0001;
		end
	end
	detect_len_a: assert property (@(posedge core_clk) disable iff (rst)
		state_reg == epd_cmd_pkg::SEQ_DETECT |-> det_cnt_reg < 13'(epd_cmd_pkg::DETECT_CYC))
		else $error("detection ran too long");
	cover_update_c: cover property (@(posedge core_clk) act_hit ##[1:400] stage_index == 3'h6);
	cover_detect_c: cover property (@(posedge core_clk) det_hit);
	cover_ramwr_c: cover property (@(posedge core_clk) ram_we ##[1:60] ram_we);
	cover_swrst_c: cover property (@(posedge core_clk) swrst_hit);
endmodule : epd_command_decoder

// File: shared/epd_cmd_pkg.sv
// Purpose: Shared constants for the panel driver command decoder
// Assumes: Core clock of 40 MHz
// Notes: Functional notes follow
package epd_cmd_pkg;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_SLEEP = 8'h10;
	localparam logic [7:0] CMD_ENTRY = 8'h11;
	localparam logic [7:0] CMD_SWRST = 8'h12;
	localparam logic [7:0] CMD_TEMP = 8'h1a;
	localparam logic [7:0] CMD_ACT = 8'h20;
	localparam logic [7:0] CMD_UPD1 = 8'h21;
	localparam logic [7:0] CMD_UPD2 = 8'h22;
	localparam logic [7:0] CMD_DETECT = 8'h23;
	localparam logic [7:0] CMD_WRAM = 8'h24;
	localparam logic [7:0] CMD_VCOM = 8'h2c;
	localparam logic [7:0] CMD_STATUS = 8'h2f;
	localparam logic [7:0] CMD_LUT = 8'h32;
	localparam logic [7:0] CMD_DUMMY = 8'h3a;
	localparam logic [7:0] CMD_GATE = 8'h3b;
	localparam logic [7:0] CMD_BORDER = 8'h3c;
	localparam logic [7:0] CMD_XWIN = 8'h44;
	localparam logic [7:0] CMD_YWIN = 8'h45;
	localparam logic [7:0] CMD_XCNT = 8'h4e;
	localparam logic [7:0] CMD_YCNT = 8'h4f;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] ENTRY_RST = 3'h3;
	localparam logic [15:0] TEMP_RST = 16'h7ff0;
	localparam logic [7:0] UPD1_RST = 8'h01;
	localparam logic [7:0] UPD2_RST = 8'hff;
	localparam logic [7:0] VCOM_RST = 8'h00;
	localparam logic [6:0] DUMMY_RST = 7'h06;
	localparam logic [3:0] GATE_RST = 4'hb;
	localparam logic [7:0] BORDER_RST = 8'h71;
	localparam logic [4:0] XEND_RST = 5'h12;
	localparam logic [7:0] YEND_RST = 8'hf9;
	// ----------------------------------------
	// Field positions and table length
	// ----------------------------------------
	localparam int ENTRY_AXIS_BIT = 2;
	localparam int BYPASS_EN_BIT = 7;
	localparam int BYPASS_VAL_BIT = 4;
	localparam int BORDER_FOLLOW_BIT = 7;
	localparam int BORDER_FIXED_BIT = 6;
	localparam int STATUS_FLAG_BIT = 3;
	localparam int LUT_BYTES = 30;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int STAGE_NS = 1000;
	localparam int DETECT_NS = 2000;
	localparam int STAGE_CYC = (STAGE_NS * CLK_MHZ + 999) / 1000;
	localparam int DETECT_CYC = (DETECT_NS * CLK_MHZ + 999) / 1000;
	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STAGE = 2'b01,
		SEQ_DETECT = 2'b10
	} seq_state_t;
endpackage : epd_cmd_pkg

// File: verilog/bit_sync.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input changes slowly against clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg; // First stage
	// Two stages, synchronous clear
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			dout <= '0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule : bit_sync

// File: verilog/serial_rx.sv
// Purpose: Serial receiver on the link clock
// Assumes: Host holds chip select low for a frame
// Notes: Byte and flag stay stable until next byte
`timescale 1ns/1ps
module serial_rx (
	input wire logic sclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic serial_data_in,
	input wire logic dc_pin,
	input wire logic wire_count_select,
	output logic [7:0] byte_reg,
	output logic dc_reg,
	output logic toggle_reg
);
	logic [3:0] cnt_reg; // Bits taken this unit
	logic [7:0] shift_reg; // Shift register
	logic dc_bit_reg; // Three-wire D/C bit
	logic [1:0] mode_reg; // Strap synchroniser
	wire three_wire = mode_reg[1];
	wire [3:0] last_cnt = three_wire ? 4'h8 : 4'h7;
	wire last_bit = cnt_reg == last_cnt;
	// ----------------------------------------
	// Bit counter, cleared by end of frame
	// ----------------------------------------
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			cnt_reg <= 4'h0;
		end else begin
			cnt_reg <= last_bit ? 4'h0 : cnt_reg + 4'h1;
		end
	end
	// Shift MSB first, D/C bit first in three-wire
	always_ff @(posedge sclk) begin
		mode_reg <= {mode_reg[0], wire_count_select};
		if (three_wire && cnt_reg == 4'h0) begin
			dc_bit_reg <= serial_data_in;
		end
		shift_reg <= {shift_reg[6:0], serial_data_in};
	end
	// Hand byte over and flip the event toggle
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			byte_reg <= 8'h00;
			dc_reg <= 1'b0;
			toggle_reg <= 1'b0;
		end else if (!cs_n && last_bit) begin
			byte_reg <= {shift_reg[6:0], serial_data_in};
			dc_reg <= three_wire ? dc_bit_reg : dc_pin;
			toggle_reg <= ~toggle_reg;
		end
	end
endmodule : serial_rx

// File: dv/spi_host_model.sv
// Purpose: Host controller model driving the serial command link
// Assumes: Link clock period 30 ns, link clock idle low outside frames
// Notes: Every frame waits for busy low before it starts
`timescale 1ns/1ps
module spi_host_model (
	output logic sclk,
	output logic cs_n,
	output logic serial_data_in,
	output logic dc_pin,
	input wire logic wire_count_select,
	input wire logic busy
);
	// ----------------------------------------
	// Frame driver
	// ----------------------------------------
	// Idle levels at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_data_in = 1'b1;
		dc_pin = 1'b0;
	end
	// Sends one byte as command (dc low) or data (dc high)
	task automatic send(input logic dc, input logic [7:0] b);
		logic [8:0] frame;
		frame = {dc, b};
		while (busy !== 1'b0) #25;
		dc_pin = wire_count_select ? 1'b0 : dc;
		cs_n = 1'b0;
		#40;
		// Nine bits in three-wire mode, eight otherwise
		for (int i = wire_count_select ? 8 : 7; i >= 0; i--) begin
			serial_data_in = frame[i];
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
		#20 cs_n = 1'b1;
		// Released line must not keep showing the last bit
		serial_data_in = ~serial_data_in;
		#100;
	endtask : send
	// Clock pulses with chip select high let the mode strap resync
	task automatic prime();
		repeat (2) begin
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
	endtask : prime
endmodule : spi_host_model

// File: dv/epd_command_decoder_test.sv
// Purpose: Self-checking bench for the command decoder
// Assumes: Core clock 25 ns, link clock 30 ns within frames and in priming bursts
// Notes: Seeded random settings plus hand-picked corner values
`timescale 1ns/1ps
module epd_command_decoder_test;
	localparam logic [1:0] CHIP_ID = 2'h2; // Arbitrary identification value
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wire_count_select = 1'b0;
	logic panel_break_pin = 1'b0;
	logic [4:0] lut_rd_index = 5'h00;
	logic sclk, cs_n, serial_data_in, dc_pin, busy, ram_we, stage_valid;
	logic internal_clock_enable, deep_sleep, bypass_enable, bypass_value, border_follow, border_fixed;
	logic [4:0] ram_x;
	logic [7:0] ram_y, ram_wdata, vcom_code, status_byte, lut_byte;
	logic [2:0] stage_index;
	logic [15:0] temp_value;
	logic [6:0] dummy_period;
	logic [3:0] gate_width;
	logic [1:0] source_mapping, border_level, border_transition;
	int fail_count = 0;
	int checked = 0;
	logic [20:0] wr_q[$]; // Captured RAM writes
	logic [2:0] stg_q[$]; // Captured stage order
	int busy_run = 0; // Busy cycles in the current run
	int busy_last = 0; // Length of the last finished run
	always #12.5 core_clk = ~core_clk;
	spi_host_model i_spi_host_model (.sclk, .cs_n, .serial_data_in, .dc_pin, .wire_count_select, .busy);
	epd_command_decoder #(.LUT_N(30)) i_epd_command_decoder (.core_clk, .rst, .sclk, .cs_n,
		.serial_data_in, .dc_pin, .wire_count_select, .panel_break_pin, .lut_rd_index, .busy, .ram_we,
		.ram_x, .ram_y, .ram_wdata, .stage_index, .stage_valid, .internal_clock_enable, .deep_sleep,
		.temp_value, .vcom_code, .status_byte, .lut_byte, .dummy_period, .gate_width, .bypass_enable,
		.bypass_value, .source_mapping, .border_follow, .border_fixed, .border_level, .border_transition);
	// Records writes and each new running stage
	always @(posedge core_clk) begin
		if (ram_we === 1'b1) wr_q.push_back({ram_x, ram_y, ram_wdata});
		if (stage_valid === 1'b1 && (stg_q.size() == 0 || stg_q[$] !== stage_index)) stg_q.push_back(stage_index);
	end
	// Measures each busy run from its first to its last cycle
	always @(posedge core_clk) begin
		if (busy === 1'b1) begin
			busy_run <= busy_run + 1;
		end else begin
			if (busy_run != 0) busy_last <= busy_run;
			busy_run <= 0;
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic cmd(input logic [7:0] c);
		i_spi_host_model.send(1'b0, c);
	endtask : cmd
	task automatic data(input logic [7:0] d);
		i_spi_host_model.send(1'b1, d);
	endtask : data
	task automatic settle();
		repeat (8) @(posedge core_clk);
	endtask : settle
	// Address after one write from x 05h, y 64h in entry mode m
	function automatic logic [12:0] next_addr(input logic [2:0] m);
		logic [4:0] x;
		logic [7:0] y;
		x = 5'h05;
		y = 8'h64;
		if (m[2]) y = m[1] ? y + 8'h01 : y - 8'h01;
		else x = m[0] ? x + 5'h01 : x - 5'h01;
		return {x, y};
	endfunction : next_addr
	// Waits out one busy run, bounded, and returns its length
	task automatic busy_len(output int n);
		for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge core_clk);
		for (int i = 0; i < 1000 && busy === 1'b1; i++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		n = busy_last;
	endtask : busy_len
	// Watchdog sized well above the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		fail_count++;
		conclude();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] a, b, lut[30];
		logic [7:0] ucode[4];
		int n, en;
		ucode = '{8'hff, 8'hd7, 8'hc7, 8'h80};
		void'($urandom(47));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		// Mode strap resync needs link clock edges before the first frame
		i_spi_host_model.prime();
		// Defaults after reset
		check(temp_value, 16'h7ff0);
		check({bypass_enable, bypass_value, source_mapping}, 4'h1);
		check({border_follow, border_fixed, border_level, border_transition}, 6'h1d);
		check({ram_x, ram_y, busy, deep_sleep, dummy_period, gate_width}, {15'h0000, 7'h06, 4'hb});
		// Random settings, first pass uses extreme values
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 8'hff : 8'($urandom);
			b = (k == 0) ? 8'h00 : 8'($urandom);
			cmd(8'h1a); data(a); data(b);
			cmd(8'h2c); data(a);
			cmd(8'h3a); data(a);
			cmd(8'h3b); data(b);
			cmd(8'h3c); data(b);
			cmd(8'h21); data(a);
			settle();
			check(temp_value, {a, b});
			check(vcom_code, a);
			check({dummy_period, gate_width}, {a[6:0], b[3:0]});
			check({border_follow, border_fixed, border_level, border_transition}, {b[7:4], b[1:0]});
			check({bypass_enable, bypass_value, source_mapping}, {a[7], a[4], a[1:0]});
		end
		// Three-wire framing
		wire_count_select <= 1'b1;
		i_spi_host_model.prime();
		cmd(8'h2c); data(8'h9b);
		settle();
		check(vcom_code, 8'h9b);
		wire_count_select <= 1'b0;
		i_spi_host_model.prime();
		// Every entry mode, two writes each
		for (int m = 0; m < 8; m++) begin
			a = 8'($urandom);
			cmd(8'h11); data(8'(m));
			cmd(8'h4e); data(8'h05);
			cmd(8'h4f); data(8'h64);
			wr_q.delete();
			cmd(8'h24); data(a); data(~a);
			settle();
			check(wr_q.size(), 2);
			check(wr_q[0], {13'h0564, a});
			check(wr_q[1], {next_addr(3'(m)), ~a});
		end
		// Detection refused while the internal clock is off
		cmd(8'h23);
		settle();
		check(busy, 1'b0);
		// Update stage lists
		foreach (ucode[k]) begin
			cmd(8'h22); data(ucode[k]);
			stg_q.delete();
			cmd(8'h20);
			busy_len(n);
			en = 0;
			for (int s = 0; s < 7; s++) begin
				if (ucode[k][(s < 2) ? 7 - s : 6 - s]) begin
					check(stg_q[en], s);
					en++;
				end
			end
			check(stg_q.size(), en);
			check(n, en * epd_cmd_pkg::STAGE_CYC + 7 - en);
			check(internal_clock_enable, ucode[k][7] & ~ucode[k][0]);
		end
		// Detection with the clock enabled, panel broken
		panel_break_pin <= 1'b1;
		cmd(8'h23);
		busy_len(n);
		check(n, epd_cmd_pkg::DETECT_CYC);
		cmd(8'h2f);
		settle();
		check(status_byte, {4'h0, 1'b1, 1'b0, CHIP_ID});
		// Table load then readback
		cmd(8'h32);
		foreach (lut[i]) begin
			lut[i] = 8'($urandom);
			data(lut[i]);
		end
		settle();
		foreach (lut[i]) begin
			lut_rd_index <= 5'(i);
			@(posedge core_clk);
			@(posedge core_clk);
			check(lut_byte, lut[i]);
		end
		// Software reset keeps deep sleep
		cmd(8'h10); data(8'h01);
		cmd(8'h1a); data(8'h12); data(8'h34);
		cmd(8'h12);
		settle();
		check({temp_value, deep_sleep, ram_x, ram_y}, {16'h7ff0, 1'b1, 13'h0000});
		conclude();
	end
endmodule : epd_command_decoder_test
